/* File: logic/ple_pkg.sv */
/*
   Package for the programmable logic equation bank: sizes, gate codes,
   timer widths and the packed configuration/status records.
   Assumes one system clock; all configuration is static while running.
*/
package ple_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int  PLE_NUM_EQ     = 8;     // Equations in the bank
   localparam int  PLE_NUM_EXT    = 16;    // External assignable signals
   localparam int  PLE_NUM_IN     = 4;     // Inputs per equation
   localparam int  PLE_NUM_SRC    = PLE_NUM_EXT + PLE_NUM_EQ;
   localparam int  PLE_SEL_W      = 5;     // Wide enough for PLE_NUM_SRC
   localparam int  PLE_IDX_W      = 3;     // Equation index width
   localparam int  PLE_TMR_W      = 16;    // Delay counter width, in cycles

   // ----------------------------------------------------------------
   // Gate selection
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PLE_GATE_AND,
      PLE_GATE_OR,
      PLE_GATE_NAND,
      PLE_GATE_NOR
   } ple_gate_t;

   // ----------------------------------------------------------------
   // Records
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [PLE_NUM_IN-1:0][PLE_SEL_W-1:0] in_sel;     // Input source select
      logic [PLE_NUM_IN-1:0]                in_inv;     // Input negate
      ple_gate_t                            gate;       // Gate function
      logic [PLE_TMR_W-1:0]                 rise_delay_time; // On delay
      logic [PLE_TMR_W-1:0]                 fall_delay_time; // Off delay
      logic [PLE_SEL_W-1:0]                 rst_sel;    // Latch reset source
      logic                                 rst_inv;    // Latch reset negate
   } ple_cfg_t;

   typedef struct packed {
      logic [PLE_NUM_IN-1:0] ins;        // Inputs after negation
      logic                  unlatched;  // Timer stage output
      logic                  latched;    // Latched output
      logic                  latched_n;  // Complement of latched
   } ple_stat_t;

   localparam logic [PLE_TMR_W-1:0] PLE_TMR_ZERO = '0;
   localparam logic [PLE_TMR_W-1:0] PLE_TMR_ONE  = 16'h0001;

endpackage : ple_pkg

/* File: logic/ple_eq.sv */
/*
   One equation: gate over four prepared inputs, on/off delay timer,
   reset-dominant latch. Called once per evaluation pass via step_in.
   Assumes inputs already selected and negated by the sequencer.
*/
`timescale 1ns/1ps
module ple_eq
   import ple_pkg::*;
(
   input  wire logic                     clk_sys_in,
   input  wire logic                     rst_n_in,
   input  wire logic                     step_in,
   input  wire logic [PLE_NUM_IN-1:0]    ins_in,
   input  wire ple_pkg::ple_gate_t       gate_in,
   input  wire logic [PLE_TMR_W-1:0]     rise_in,
   input  wire logic [PLE_TMR_W-1:0]     fall_in,
   input  wire logic                     rst_lat_in,
   output logic                          gate_out,
   output logic                          unl_out,
   output logic                          lat_out
);

   logic                 out_q, out_d;
   logic                 lat_q, lat_d;
   logic [PLE_TMR_W-1:0] cnt_q, cnt_d;

   // ----------------------------------------------------------------
   // Gate, timer and latch
   // ----------------------------------------------------------------
   always_comb
   begin
      case (gate_in)
         PLE_GATE_AND:  gate_out = &ins_in;
         PLE_GATE_OR:   gate_out = |ins_in;
         PLE_GATE_NAND: gate_out = ~&ins_in;
         PLE_GATE_NOR:  gate_out = ~|ins_in;
         default:       gate_out = 1'b0;
      endcase
      out_d = out_q;
      cnt_d = cnt_q;
      lat_d = lat_q;
      if (step_in)
      begin
         // Timer counts passes, so delays are in evaluation cycles
         if (gate_out == out_q)
            cnt_d = PLE_TMR_ZERO;
         else if ((gate_out ? rise_in : fall_in) <= cnt_d + PLE_TMR_ONE)
         begin
            out_d = gate_out;
            cnt_d = PLE_TMR_ZERO;
         end
         else
            cnt_d = cnt_q + PLE_TMR_ONE;
         // Reset wins over set
         if (rst_lat_in)
            lat_d = 1'b0;
         else if (out_d)
            lat_d = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         out_q <= 1'b0;
         lat_q <= 1'b0;
         cnt_q <= PLE_TMR_ZERO;
      end
      else
      begin
         out_q <= out_d;
         lat_q <= lat_d;
         cnt_q <= cnt_d;
      end
   end

   // Same-pass view so that a higher equation sees this pass's result
   assign unl_out = out_d;
   assign lat_out = lat_d;

   lat_reset_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      step_in && rst_lat_in |=> !lat_q) else $error("latch not cleared");
   lat_set_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      step_in && !rst_lat_in && out_d |=> lat_q) else $error("latch not set");
   lat_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      !step_in |=> $stable(lat_q) && $stable(out_q)) else $error("state moved off step");
   zero_delay_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      step_in && gate_out && rise_in == PLE_TMR_ZERO |=> out_q) else $error("zero on delay");

endmodule : ple_eq

/* File: logic/ple_bank.sv */
/*
   Bank of programmable logic equations. A sequencer walks equation 0 up
   to the last, one per clock, and restarts; that full walk is one
   evaluation cycle. Assumes configuration ports are static or change
   only between passes; external signals are asynchronous pins.
*/
//
// Overview of operation
// - Four inputs selected from assignable signals
// - Each input can be negated
// - Timer applies rise and fall delays
// - Unlatched and latched outputs together
// - Complement of latched output provided
// - Latch reset selectable and optionally negated
// - Reset dominates set in latch
// - Equations evaluated ascending, pass repeats forever
// - Equation outputs selectable as inputs
// - Ascending cascade settles in same pass
// - Descending cascade lags one pass
// - Input and output states are observable
`timescale 1ns/1ps
module ple_bank
   import ple_pkg::*;
#(
   parameter int NUM_EQ  = PLE_NUM_EQ,
   parameter int NUM_EXT = PLE_NUM_EXT
)
(
   input  wire logic                              clk_sys_in,
   input  wire logic                              rst_n_in,
   input  wire logic [NUM_EXT-1:0]                ext_sig_in,
   input  wire ple_pkg::ple_cfg_t [NUM_EQ-1:0]    cfg_in,
   output ple_pkg::ple_stat_t [NUM_EQ-1:0]        stat_out,
   output logic                                   pass_done_out
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic {
      PLE_ST_RUN,
      PLE_ST_WRAP
   } ple_seq_t;

   localparam int                 SRC_N = NUM_EXT + NUM_EQ;
   localparam logic [PLE_IDX_W-1:0] IDX_LAST = PLE_IDX_W'(NUM_EQ - 1);
   localparam logic [PLE_IDX_W-1:0] IDX_ZERO = '0;
   // Complement starts high so it already agrees with the cleared latch
   localparam ple_stat_t STAT_RST = '{ins: '0, unlatched: 1'b0, latched: 1'b0, latched_n: 1'b1};

   logic [NUM_EXT-1:0]   sync1_q, sync2_q;
   logic [NUM_EXT-1:0]   ext_pass_q, ext_pass_d;
   logic [PLE_IDX_W-1:0] idx_q, idx_d;
   ple_seq_t             st_q, st_d;
   logic [NUM_EQ-1:0]    unl_q, unl_d;
   logic [NUM_EQ-1:0]    lat_q, lat_d;
   ple_stat_t [NUM_EQ-1:0] stat_q, stat_d;
   logic                 done_q, done_d;
   // Working copy of the prepared inputs, published only at the wrap
   logic [NUM_EQ-1:0][PLE_NUM_IN-1:0] ins_q, ins_d;

   logic [PLE_NUM_IN-1:0] cur_ins;
   logic                  cur_rst;
   logic [NUM_EQ-1:0]     eq_step;
   logic [NUM_EQ-1:0]     eq_unl;
   logic [NUM_EQ-1:0]     eq_lat;
   logic                  cur_unl;
   logic                  cur_lat;
   ple_cfg_t              cur_cfg;
   logic [SRC_N-1:0]      src;

   // Picks one source out of the flat assignable list
   function automatic logic pick(input logic [SRC_N-1:0] s, input logic [PLE_SEL_W-1:0] sel);
      pick = (int'(sel) < SRC_N) ? s[sel] : 1'b0;
   endfunction : pick

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= ext_sig_in;
         sync2_q <= sync1_q;
      end
   end

   // ----------------------------------------------------------------
   // Source list and input preparation for the current equation
   // ----------------------------------------------------------------
   always_comb
   begin
      cur_cfg = cfg_in[idx_q];
      // Outputs from this pass overwrite unl_q as the walk proceeds, so
      // lower equations are fresh and higher ones are last pass's value
      src = {unl_q, ext_pass_q};
      for (int i = 0; i < PLE_NUM_IN; i++)
         cur_ins[i] = pick(src, cur_cfg.in_sel[i]) ^ cur_cfg.in_inv[i];
      cur_rst = pick(src, cur_cfg.rst_sel) ^ cur_cfg.rst_inv;
      // Only the equation under the walk may move its timer and latch
      eq_step = '0;
      if (st_q == PLE_ST_RUN)
         eq_step[idx_q] = 1'b1;
   end

   // One timer and latch per equation; a shared one would leak state
   // from one equation into the next as the walk moves on
   for (genvar e = 0; e < NUM_EQ; e++)
   begin : g_eq
      ple_eq u_eq (
         .clk_sys_in (clk_sys_in),
         .rst_n_in   (rst_n_in),
         .step_in    (eq_step[e]),
         .ins_in     (cur_ins),
         .gate_in    (cfg_in[e].gate),
         .rise_in    (cfg_in[e].rise_delay_time),
         .fall_in    (cfg_in[e].fall_delay_time),
         .rst_lat_in (cur_rst),
         .gate_out   (),
         .unl_out    (eq_unl[e]),
         .lat_out    (eq_lat[e])
      );
   end

   // Result of the equation under the walk
   assign cur_unl = eq_unl[idx_q];
   assign cur_lat = eq_lat[idx_q];

   // ----------------------------------------------------------------
   // Sequencer and result store
   // ----------------------------------------------------------------
   always_comb
   begin
      idx_d      = idx_q;
      st_d       = st_q;
      ext_pass_d = ext_pass_q;
      unl_d      = unl_q;
      lat_d      = lat_q;
      stat_d     = stat_q;
      ins_d      = ins_q;
      done_d     = 1'b0;
      unl_d[idx_q] = cur_unl;
      lat_d[idx_q] = cur_lat;
      case (st_q)
         PLE_ST_RUN:
         begin
            if (idx_q == IDX_LAST)
            begin
               idx_d = IDX_ZERO;
               st_d  = PLE_ST_WRAP;
            end
            else
               idx_d = idx_q + PLE_IDX_W'(1);
         end
         PLE_ST_WRAP:
         begin
            // Publish the finished pass, sample pins for the next one
            for (int e = 0; e < NUM_EQ; e++)
               stat_d[e] = '{ins: ins_q[e], unlatched: unl_q[e],
                              latched: lat_q[e], latched_n: ~lat_q[e]};
            ext_pass_d = sync2_q;
            done_d     = 1'b1;
            unl_d      = unl_q;
            lat_d      = lat_q;
            st_d       = PLE_ST_RUN;
         end
         default:
            st_d = PLE_ST_RUN;
      endcase
      if (st_q == PLE_ST_RUN)
         ins_d[idx_q] = cur_ins;
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         idx_q      <= IDX_ZERO;
         st_q       <= PLE_ST_RUN;
         ext_pass_q <= '0;
         unl_q      <= '0;
         lat_q      <= '0;
         for (int e = 0; e < NUM_EQ; e++)
            stat_q[e] <= STAT_RST;
         ins_q      <= '0;
         done_q     <= 1'b0;
      end
      else
      begin
         idx_q      <= idx_d;
         st_q       <= st_d;
         ext_pass_q <= ext_pass_d;
         unl_q      <= unl_d;
         lat_q      <= lat_d;
         stat_q     <= stat_d;
         ins_q      <= ins_d;
         done_q     <= done_d;
      end
   end

   assign stat_out      = stat_q;
   assign pass_done_out = done_q;

   seq_wrap_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      st_q == PLE_ST_RUN && idx_q == IDX_LAST |=> st_q == PLE_ST_WRAP ##1 idx_q == IDX_ZERO)
      else $error("pass order broken");
   lat_comp_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      stat_q[0].latched_n == ~stat_q[0].latched) else $error("complement wrong");
   done_pulse_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      pass_done_out |=> !pass_done_out) else $error("done not a pulse");
   ext_frozen_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      st_q == PLE_ST_RUN |=> $stable(ext_pass_q)) else $error("inputs moved mid pass");

   // ----------------------------------------------------------------
   // Walk decode and publish step
   // ----------------------------------------------------------------
   sequence wrap_s;
      st_q == PLE_ST_WRAP;
   endsequence
   sequence publish_s;
      pass_done_out && stat_out[IDX_ZERO].unlatched == $past(unl_q[IDX_ZERO]);
   endsequence

   stat_pub_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      wrap_s |=> publish_s) else $error("pass not published");
   step_onehot_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      $onehot0(eq_step)) else $error("more than one equation stepped");

endmodule : ple_bank

/* File: testbench/testbench.sv */
/*
   Self-checking bench for the logic equation bank: random configurations
   with a per-pass model, plus cascade and delay corner cases.
   Assumes default bank sizes and configuration held still between checks.
*/
`timescale 1ns/1ps
module testbench;
   import ple_pkg::*;

   logic            clk_sys_in = 1'b0;
   logic            rst_n_in   = 1'b0;
   logic [15:0]     ext        = 16'h0000;
   ple_cfg_t [7:0]  cfg        = '0;
   ple_stat_t [7:0] stat;
   logic            pass_done;
   logic [15:0]     rnd        = 16'hf0dd;
   logic [7:0]      lat_m      = 8'h00;
   logic [15:0]     r;
   int              err_total  = 0;
   int              cmp_count  = 0;
   int              j;

   // 200 MHz system clock
   always #2.5 clk_sys_in = ~clk_sys_in;

   ple_bank #(.NUM_EQ(8), .NUM_EXT(16)) uut (
      .clk_sys_in    (clk_sys_in),
      .rst_n_in      (rst_n_in),
      .ext_sig_in    (ext),
      .cfg_in        (cfg),
      .stat_out      (stat),
      .pass_done_out (pass_done)
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task draw;
      rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
      r   = rnd;
   endtask : draw

   task stop_test;
      if (err_total == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Bounded wait for n published passes; returns on a falling edge
   task wait_pass(input int n);
      int k;
      repeat (n)
      begin
         k = 0;
         do
         begin
            @(negedge clk_sys_in);
            k++;
         end while (pass_done !== 1'b1 && k < 40);
         if (k >= 40)
         begin
            err_total++;
            stop_test();
         end
      end
   endtask : wait_pass

   // Gate model of one equation: {negated inputs, gate result}
   function automatic logic [4:0] eq_model(input int k, input logic [7:0] u);
      logic [3:0] x;
      logic [4:0] s;
      for (int i = 0; i < 4; i++)
      begin
         s    = cfg[k].in_sel[i];
         x[i] = ((s < 16) ? ext[s[3:0]] : (s < 24) ? u[s[2:0]] : 1'b0) ^ cfg[k].in_inv[i];
      end
      case (cfg[k].gate)
         PLE_GATE_AND:  return {x, &x};
         PLE_GATE_OR:   return {x, |x};
         PLE_GATE_NAND: return {x, ~&x};
         default:       return {x, ~|x};
      endcase
   endfunction : eq_model

   // Ascending walk of the model; latch reset dominates set
   task check_all;
      logic [4:0] m;
      logic [7:0] u;
      logic       rs;
      u = 8'h00;
      for (int k = 0; k < 8; k++)
      begin
         m        = eq_model(k, u);
         u[k]     = m[0];
         rs       = ext[cfg[k].rst_sel[3:0]] ^ cfg[k].rst_inv;
         lat_m[k] = !rs & (lat_m[k] | u[k]);
         chk(16'({stat[k].ins, stat[k].unlatched, stat[k].latched, stat[k].latched_n}),
             16'({m[4:1], u[k], lat_m[k], !lat_m[k]}));
      end
   endtask : check_all

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (6) @(negedge clk_sys_in);
      rst_n_in = 1'b1;
      // Random sources draw only from lower equations so each pass settles
      for (int n = 0; n < 40; n++)
      begin
         for (int k = 0; k < 8; k++)
         begin
            for (int i = 0; i < 4; i++)
            begin
               draw();
               cfg[k].in_sel[i] = 5'(r[15:8] % (16 + k));
               cfg[k].in_inv[i] = r[0];
               cfg[k].gate      = ple_gate_t'(r[2:1]);
            end
            cfg[k].rst_sel = 5'h0f;
            cfg[k].rst_inv = 1'b0;
         end
         draw();
         ext = r | 16'h8000;
         wait_pass(3);
         check_all();
         for (int k = 0; k < 8; k++)
         begin
            draw();
            cfg[k].rst_sel = {1'b0, r[3:0]};
            cfg[k].rst_inv = r[4];
         end
         wait_pass(3);
         check_all();
         draw();
         ext = r;
         wait_pass(3);
         check_all();
      end
      // Chain: eq1 from ext bit 0, eq2..7 ascending, eq0 fed back from eq1
      for (int k = 0; k < 8; k++)
      begin
         cfg[k] = '0;
         for (int i = 0; i < 4; i++)
            cfg[k].in_sel[i] = (k == 1) ? 5'h00 : (k == 0) ? 5'h11 : 5'(15 + k);
         cfg[k].rst_sel = 5'h0f;
         cfg[k].rst_inv = 1'b1;
      end
      ext = 16'h8000;
      wait_pass(3);
      ext[0] = 1'b1;
      j = 0;
      do
      begin
         wait_pass(1);
         j++;
      end while (stat[1].unlatched !== 1'b1 && j < 6);
      chk(16'(stat[1].unlatched), 16'h0001);
      chk(16'(stat[7].unlatched), 16'h0001);
      chk(16'(stat[0].unlatched), 16'h0000);
      wait_pass(1);
      chk(16'(stat[0].unlatched), 16'h0001);
      // Same timed equation everywhere, so a shared timer cannot hide a slip
      for (int k = 0; k < 8; k++)
      begin
         cfg[k].in_sel          = '0;
         cfg[k].rise_delay_time = 16'h0004;
         cfg[k].fall_delay_time = 16'h0004;
      end
      ext[0] = 1'b0;
      wait_pass(12);
      ext[0] = 1'b1;
      wait_pass(2);
      chk(16'(stat[3].unlatched), 16'h0000);
      wait_pass(10);
      chk(16'(stat[3].unlatched), 16'h0001);
      ext[0] = 1'b0;
      wait_pass(2);
      chk(16'(stat[3].unlatched), 16'h0001);
      wait_pass(10);
      chk(16'(stat[3].unlatched), 16'h0000);
      chk(16'(stat[3].latched), 16'h0001);
      stop_test();
   end

endmodule : testbench
